/* design/tmr8_pkg.sv */
// shared constants for the triple 8-bit interval timer
package tmr8_pkg;
   localparam int          NUM_CH        = 3;
   localparam int          NUM_DIV       = 6;
   localparam int          PRE_W         = 10;
   // exponents of the main clock dividers: ch0 {6,9}, ch1 {4,8}, ch2 {3,10}
   localparam int          DIV_EXP [NUM_DIV] = '{6, 9, 4, 8, 3, 10};
   // register addresses on the special function register port
   localparam logic [15:0] ADDR_PORT2_DIR = 16'hFF22;
   localparam logic [15:0] ADDR_MODE [NUM_CH] = '{16'hFF59, 16'hFF5C, 16'hFF5F};
   localparam logic [15:0] ADDR_CNT  [NUM_CH] = '{16'hFF50, 16'hFF51, 16'hFF52};
   localparam logic [15:0] ADDR_CMP  [NUM_CH] = '{16'hFF54, 16'hFF55, 16'hFF56};
   // reset values
   localparam logic [7:0]  MODE_RST      = 8'h00;
   localparam logic [7:0]  PORT2_DIR_RST = 8'hFF;
   localparam logic [7:0]  CNT_RST       = 8'h00;
   localparam logic [7:0]  RDATA_RST     = 8'h00;
   // writable bits of each mode register; the rest read zero
   localparam logic [7:0]  MODE_MASK [NUM_CH] = '{8'h86, 8'h86, 8'h87};
   // field positions in the mode registers
   localparam int          RUN_BIT       = 7;
   localparam int          CLKSEL_HI     = 2;
   localparam int          CLKSEL_LO     = 1;
   localparam int          OUT_EN_BIT    = 0;
   // port 2 pins used by the timers
   localparam int          DIR_EXT_BIT   = 3;
   localparam int          DIR_SQW_BIT   = 5;
   // clock source codes
   localparam logic [1:0]  SEL_DIV_A     = 2'h0;
   localparam logic [1:0]  SEL_DIV_B     = 2'h1;
   localparam logic [1:0]  SEL_SUB_RISE  = 2'h2;
   localparam logic [1:0]  SEL_FALL      = 2'h3;
   localparam int          SQW_CH        = 2;
   localparam int          EXT_CH        = 0;
endpackage : tmr8_pkg

/* design/count_pulse_gen.sv */
// prescaler and edge detectors producing one-cycle count pulses
`timescale 1ns/100ps
`default_nettype none
module count_pulse_gen (
   input  wire logic                            mclk,
   input  wire logic                            rstn,
   input  wire logic                            sub_clk,
   input  wire logic                            ext_count_input,
   output logic [tmr8_pkg::NUM_DIV-1:0]         div_tick,
   output logic                                 sub_tick,
   output logic                                 ext_rise,
   output logic                                 ext_fall
);
   logic [tmr8_pkg::PRE_W-1:0]   pre_q, pre_d;
   logic [tmr8_pkg::NUM_DIV-1:0] div_q, div_d;
   logic                         sub_q, ext_q;
   logic                         sub_tick_q, sub_tick_d;
   logic                         rise_q, rise_d, fall_q, fall_d;

   // free running so every channel stays phase locked to the same prescaler
   always_comb begin
      pre_d      = pre_q + 1'b1;
      sub_tick_d = sub_clk & ~sub_q;
      rise_d     = ext_count_input & ~ext_q;
      fall_d     = ~ext_count_input & ext_q;
   end

   genvar g;
   for (g = 0; g < tmr8_pkg::NUM_DIV; g++) begin : g_div
      always_comb begin
         div_d[g] = &pre_q[tmr8_pkg::DIV_EXP[g]-1:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pre_q      <= '0;
         div_q      <= '0;
         sub_q      <= 1'b0;
         ext_q      <= 1'b0;
         sub_tick_q <= 1'b0;
         rise_q     <= 1'b0;
         fall_q     <= 1'b0;
      end else begin
         pre_q      <= pre_d;
         div_q      <= div_d;
         sub_q      <= sub_clk;
         ext_q      <= ext_count_input;
         sub_tick_q <= sub_tick_d;
         rise_q     <= rise_d;
         fall_q     <= fall_d;
      end
   end

   assign div_tick = div_q;
   assign sub_tick = sub_tick_q;
   assign ext_rise = rise_q;
   assign ext_fall = fall_q;
endmodule : count_pulse_gen
`default_nettype wire

/* design/timer_channel.sv */
// one 8-bit up counter with compare and clear on match
`timescale 1ns/100ps
`default_nettype none
module timer_channel (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       run,
   input  wire logic       tick,
   input  wire logic [7:0] compare_value,
   output logic      [7:0] counter_value,
   output logic            match_irq
);
   logic [7:0] cnt_q, cnt_d;
   logic       match_q, match_d;

   always_comb begin
      cnt_d   = cnt_q;
      match_d = 1'b0;
      if (!run) begin
         cnt_d = tmr8_pkg::CNT_RST;
      end else if (tick) begin
         if (cnt_q == compare_value) begin
            cnt_d   = tmr8_pkg::CNT_RST;
            match_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_q   <= tmr8_pkg::CNT_RST;
         match_q <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         match_q <= match_d;
      end
   end

   assign counter_value = cnt_q;
   assign match_irq     = match_q;
endmodule : timer_channel
`default_nettype wire

/* design/triple_8bit_interval_timer.sv */
// three 8-bit interval timers with event input and square wave output
`timescale 1ns/100ps
`default_nettype none
module triple_8bit_interval_timer (
   input  wire logic                          mclk,
   input  wire logic                          rstn,
   input  wire logic [15:0]                   sfr_addr,
   input  wire logic [7:0]                    sfr_wdata,
   input  wire logic                          sfr_wr,
   input  wire logic                          sfr_rd,
   output logic      [7:0]                    sfr_rdata,
   input  wire logic                          ext_count_input,
   input  wire logic                          sub_clk,
   output logic      [tmr8_pkg::NUM_CH-1:0]   match_irq,
   output logic                               square_wave_out,
   output logic                               square_wave_oe,
   output logic      [7:0]                    port2_direction
);
   logic [7:0]                    mode_q [tmr8_pkg::NUM_CH];
   logic [7:0]                    mode_d [tmr8_pkg::NUM_CH];
   logic [7:0]                    cmp_q  [tmr8_pkg::NUM_CH];
   logic [7:0]                    cmp_d  [tmr8_pkg::NUM_CH];
   logic [7:0]                    cnt    [tmr8_pkg::NUM_CH];
   logic [7:0]                    dir_q, dir_d;
   logic [7:0]                    rdata_q, rdata_d;
   logic                          sqw_q, sqw_d;
   logic [tmr8_pkg::NUM_CH-1:0]   run;
   logic [tmr8_pkg::NUM_CH-1:0]   tick;
   logic [tmr8_pkg::NUM_CH-1:0]   match;
   logic [tmr8_pkg::NUM_DIV-1:0]  div_tick;
   logic                          sub_tick;
   logic                          ext_rise;
   logic                          ext_fall;

   count_pulse_gen u_pulses (
      .mclk            (mclk),
      .rstn            (rstn),
      .sub_clk         (sub_clk),
      .ext_count_input (ext_count_input),
      .div_tick        (div_tick),
      .sub_tick        (sub_tick),
      .ext_rise        (ext_rise),
      .ext_fall        (ext_fall)
   );

   genvar g;
   for (g = 0; g < tmr8_pkg::NUM_CH; g++) begin : g_ch
      // register writes; software must stop the counter first, not enforced
      always_comb begin
         mode_d[g] = mode_q[g];
         cmp_d[g]  = cmp_q[g];
         if (sfr_wr && sfr_addr == tmr8_pkg::ADDR_MODE[g]) begin
            mode_d[g] = sfr_wdata & tmr8_pkg::MODE_MASK[g];
         end
         if (sfr_wr && sfr_addr == tmr8_pkg::ADDR_CMP[g]) begin
            cmp_d[g] = sfr_wdata;
         end
      end

      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            mode_q[g] <= tmr8_pkg::MODE_RST;
         end else begin
            mode_q[g] <= mode_d[g];
         end
      end

      // compare has no reset; its value is undefined until written
      always_ff @(posedge mclk) begin
         cmp_q[g] <= cmp_d[g];
      end

      // source select per channel
      always_comb begin
         run[g] = mode_q[g][tmr8_pkg::RUN_BIT];
         case (mode_q[g][tmr8_pkg::CLKSEL_HI:tmr8_pkg::CLKSEL_LO])
            tmr8_pkg::SEL_DIV_A:    tick[g] = div_tick[2*g];
            tmr8_pkg::SEL_DIV_B:    tick[g] = div_tick[2*g+1];
            tmr8_pkg::SEL_SUB_RISE: tick[g] = (g == tmr8_pkg::EXT_CH) ? ext_rise : sub_tick;
            tmr8_pkg::SEL_FALL:     tick[g] = (g == tmr8_pkg::EXT_CH) ? ext_fall : 1'b0;
            default:                tick[g] = 1'b0;
         endcase
      end

      timer_channel u_ch (
         .mclk          (mclk),
         .rstn          (rstn),
         .run           (run[g]),
         .tick          (tick[g]),
         .compare_value (cmp_q[g]),
         .counter_value (cnt[g]),
         .match_irq     (match[g])
      );
   end

   // port direction, square wave and read data
   always_comb begin
      dir_d   = dir_q;
      sqw_d   = sqw_q;
      rdata_d = tmr8_pkg::RDATA_RST;
      if (sfr_wr && sfr_addr == tmr8_pkg::ADDR_PORT2_DIR) begin
         dir_d = sfr_wdata;
      end
      // toggles on the registered match, so the pin lags the interrupt by a clock
      if (!run[tmr8_pkg::SQW_CH] || !mode_q[tmr8_pkg::SQW_CH][tmr8_pkg::OUT_EN_BIT]) begin
         sqw_d = 1'b0;
      end else if (match[tmr8_pkg::SQW_CH]) begin
         sqw_d = ~sqw_q;
      end
      if (sfr_rd) begin
         if (sfr_addr == tmr8_pkg::ADDR_PORT2_DIR) begin
            rdata_d = dir_q;
         end
         for (int i = 0; i < tmr8_pkg::NUM_CH; i++) begin
            if (sfr_addr == tmr8_pkg::ADDR_MODE[i]) begin
               rdata_d = mode_q[i];
            end
            if (sfr_addr == tmr8_pkg::ADDR_CNT[i]) begin
               rdata_d = cnt[i];
            end
            if (sfr_addr == tmr8_pkg::ADDR_CMP[i]) begin
               rdata_d = cmp_q[i];
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dir_q   <= tmr8_pkg::PORT2_DIR_RST;
         sqw_q   <= 1'b0;
         rdata_q <= tmr8_pkg::RDATA_RST;
      end else begin
         dir_q   <= dir_d;
         sqw_q   <= sqw_d;
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata       = rdata_q;
   assign match_irq       = match;
   assign square_wave_out = sqw_q;
   assign square_wave_oe  = mode_q[tmr8_pkg::SQW_CH][tmr8_pkg::OUT_EN_BIT];
   assign port2_direction = dir_q;

   // checks
   property p_stop_hold;
      @(posedge mclk) disable iff (!rstn)
      !run[0] |=> (cnt[0] == 8'h00);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped counter not held at zero");

   property p_ext_rise;
      @(posedge mclk) disable iff (!rstn)
      (mode_q[0][2:1] == 2'h2 && $rose(ext_count_input)) |=> tick[0];
   endproperty
   a_ext_rise: assert property (p_ext_rise) else $error("rising edge not counted");

   property p_mode_zero_bits;
      @(posedge mclk) disable iff (!rstn)
      sfr_wr |=> (mode_q[0][6:3] == 4'h0 && mode_q[1][6:3] == 4'h0 && mode_q[2][6:3] == 4'h0);
   endproperty
   a_mode_zero_bits: assert property (p_mode_zero_bits) else $error("mode reserved bits set");

   property p_dir_reset;
      @(posedge mclk) disable iff (!rstn)
      $rose(rstn) |-> (dir_q == 8'hFF);
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("direction register not FF after reset");

   property p_match_clear;
      @(posedge mclk) disable iff (!rstn)
      (run[1] && tick[1] && cnt[1] == cmp_q[1]) |=> (cnt[1] == 8'h00);
   endproperty
   a_match_clear: assert property (p_match_clear) else $error("counter not cleared on match");

   property p_match_irq;
      @(posedge mclk) disable iff (!rstn)
      (run[0] && tick[0] && cnt[0] == cmp_q[0]) |=> match_irq[0] ##1 !match_irq[0];
   endproperty
   a_match_irq: assert property (p_match_irq) else $error("match interrupt missing or too long");

   property p_count_up;
      @(posedge mclk) disable iff (!rstn)
      (run[2] && tick[2] && cnt[2] != cmp_q[2]) |=> (cnt[2] == $past(cnt[2]) + 8'h01);
   endproperty
   a_count_up: assert property (p_count_up) else $error("counter did not step by one");

   property p_sqw_toggle;
      @(posedge mclk) disable iff (!rstn)
      (match[2] && run[2] && mode_q[2][0]) |=> (sqw_q != $past(sqw_q));
   endproperty
   a_sqw_toggle: assert property (p_sqw_toggle) else $error("square wave did not invert");

   property p_sqw_stop;
      @(posedge mclk) disable iff (!rstn)
      !run[2] |=> !sqw_q;
   endproperty
   a_sqw_stop: assert property (p_sqw_stop) else $error("square wave not forced low");

   property p_ext_fall;
      @(posedge mclk) disable iff (!rstn)
      (mode_q[0][2:1] == 2'h3 && $fell(ext_count_input)) |=> tick[0];
   endproperty
   a_ext_fall: assert property (p_ext_fall) else $error("falling edge not counted");

   property p_no_source;
      @(posedge mclk) disable iff (!rstn)
      (mode_q[1][2:1] == 2'h3) |-> !tick[1];
   endproperty
   a_no_source: assert property (p_no_source) else $error("unused clock code produced a count");

   property p_sub_count1;
      @(posedge mclk) disable iff (!rstn)
      (mode_q[1][2:1] == 2'h2 && $rose(sub_clk)) |=> tick[1];
   endproperty
   a_sub_count1: assert property (p_sub_count1) else $error("subclock edge not counted on counter 1");

   property p_sub_count2;
      @(posedge mclk) disable iff (!rstn)
      (mode_q[2][2:1] == 2'h2 && $rose(sub_clk)) |=> tick[2];
   endproperty
   a_sub_count2: assert property (p_sub_count2) else $error("subclock edge not counted on counter 2");

   property p_oe_low;
      @(posedge mclk) disable iff (!rstn)
      !square_wave_oe |=> !square_wave_out;
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("square wave high with output disabled");

   property p_dir_write;
      @(posedge mclk) disable iff (!rstn)
      (sfr_wr && sfr_addr == tmr8_pkg::ADDR_PORT2_DIR) |=> (port2_direction == $past(sfr_wdata));
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write lost");

   property p_dir_hold;
      @(posedge mclk) disable iff (!rstn)
      !(sfr_wr && sfr_addr == tmr8_pkg::ADDR_PORT2_DIR) |=> $stable(port2_direction);
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("direction changed without a write");

   property p_cnt_hold;
      @(posedge mclk) disable iff (!rstn)
      (run[1] && !tick[1]) |=> (cnt[1] == $past(cnt[1]));
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without a count pulse");

   property p_no_spurious;
      @(posedge mclk) disable iff (!rstn)
      !(run[1] && tick[1] && cnt[1] == cmp_q[1]) |=> !match_irq[1];
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("interrupt without a match");

   property p_sqw_hold;
      @(posedge mclk) disable iff (!rstn)
      (!match[2] && run[2] && mode_q[2][0]) |=> $stable(sqw_q);
   endproperty
   a_sqw_hold: assert property (p_sqw_hold) else $error("square wave moved without a match");

   property p_stop_hold2;
      @(posedge mclk) disable iff (!rstn)
      !run[2] |=> (cnt[2] == 8'h00);
   endproperty
   a_stop_hold2: assert property (p_stop_hold2) else $error("stopped counter 2 not held at zero");

   property p_irq_pulse2;
      @(posedge mclk) disable iff (!rstn)
      match_irq[2] |=> !match_irq[2];
   endproperty
   a_irq_pulse2: assert property (p_irq_pulse2) else $error("counter 2 interrupt longer than a clock");

   property p_mode_write;
      @(posedge mclk) disable iff (!rstn)
      (sfr_wr && sfr_addr == tmr8_pkg::ADDR_MODE[1]) |=> (mode_q[1] == ($past(sfr_wdata) & 8'h86));
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write not masked");

   property p_mode_read;
      @(posedge mclk) disable iff (!rstn)
      (sfr_rd && sfr_addr == tmr8_pkg::ADDR_MODE[0]) |=> (sfr_rdata[6:3] == 4'h0);
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("mode reserved bits read nonzero");

   c_sub_count: cover property (@(posedge mclk) disable iff (!rstn) run[2] && sub_tick && mode_q[2][2:1] == 2'h2);
   c_sqw_low: cover property (@(posedge mclk) disable iff (!rstn) $fell(square_wave_out));
   c_match0: cover property (@(posedge mclk) disable iff (!rstn) match_irq[0]);
   c_sqw_high: cover property (@(posedge mclk) disable iff (!rstn) $rose(square_wave_out));
   c_ext_count: cover property (@(posedge mclk) disable iff (!rstn) run[0] && ext_fall && mode_q[0][2:1] == 2'h3);
endmodule : triple_8bit_interval_timer
`default_nettype wire

/* testbench/test_triple_8bit_interval_timer.sv */
// self-checking bench for the triple 8-bit interval timer
`timescale 1ns/100ps
`default_nettype none
module test_triple_8bit_interval_timer;
   typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} reg_row_s;
   typedef struct {int ch; logic [1:0] code; logic [7:0] cmp; logic [15:0] per;} tick_row_s;
   logic        mclk, rstn, sfr_wr, sfr_rd, ext_count_input, sub_clk;
   logic [15:0] sfr_addr;
   logic [7:0]  sfr_wdata, sfr_rdata, port2_direction;
   logic [2:0]  match_irq;
   logic        square_wave_out, square_wave_oe;
   int          err_total, comparisons, cyc, base;
   int          irq_cnt [3];
   int          last_t [3];
   logic [15:0] per [3];
   reg_row_s    regs [7];
   tick_row_s   ticks [7];

   triple_8bit_interval_timer u_triple_8bit_interval_timer (
      .mclk(mclk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ext_count_input(ext_count_input), .sub_clk(sub_clk),
      .match_irq(match_irq), .square_wave_out(square_wave_out), .square_wave_oe(square_wave_oe),
      .port2_direction(port2_direction));

   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;

   // interrupt monitor: pulse count and spacing in clocks per counter
   always @(posedge mclk) begin
      cyc++;
      for (int i = 0; i < 3; i++) begin
         if (match_irq[i] === 1'b1) begin
            per[i] = 16'(cyc - last_t[i]);
            last_t[i] = cyc;
            irq_cnt[i]++;
         end
      end
   end

   task end_of_test();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task wr(input logic [15:0] a, input logic [7:0] d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge mclk);
      sfr_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr

   // read data is registered: look 1 ns after the taking edge
   task rd(input logic [15:0] a, input logic [7:0] e);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1 chk(sfr_rdata, e);
      @(posedge mclk);
   endtask : rd

   // pulse wide enough for the synchroniser and edge detector
   task pulse(input logic is_sub);
      if (is_sub) sub_clk <= 1'b1;
      else ext_count_input <= 1'b1;
      repeat (4) @(posedge mclk);
      if (is_sub) sub_clk <= 1'b0;
      else ext_count_input <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : pulse

   task wait_irq(input int ch, input int n);
      int k;
      k = 0;
      while (irq_cnt[ch] < n && k < 10000) begin
         @(posedge mclk);
         k++;
      end
      if (k >= 10000) begin
         err_total++;
         $display("ERROR %0t: interrupt missing", $time);
         end_of_test();
      end
   endtask : wait_irq

   initial begin
      regs = '{'{16'hFF59, 8'h7E, 8'h06}, '{16'hFF5C, 8'h7F, 8'h06}, '{16'hFF5F, 8'h7F, 8'h07},
               '{16'hFF00, 8'h55, 8'h00}, '{16'hFF50, 8'h55, 8'h00}, '{16'hFF55, 8'hC3, 8'hC3},
               '{16'hFF22, 8'hA5, 8'hA5}};
      ticks = '{'{0, 2'h0, 8'h01, 16'd128}, '{0, 2'h1, 8'h00, 16'd512}, '{1, 2'h0, 8'h02, 16'd48},
                '{1, 2'h1, 8'h00, 16'd256}, '{2, 2'h0, 8'h03, 16'd32}, '{2, 2'h1, 8'h00, 16'd1024},
                '{2, 2'h0, 8'hFF, 16'd2048}};
      rstn = 1'b0;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = 16'h0000;
      sfr_wdata = 8'h00;
      ext_count_input = 1'b0;
      sub_clk = 1'b0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      #1 chk(port2_direction, 16'h00FF);
      chk(match_irq, 16'h0000);
      chk(square_wave_out, 16'h0000);
      chk(square_wave_oe, 16'h0000);
      @(posedge mclk);
      for (int i = 0; i < 3; i++) rd(tmr8_pkg::ADDR_MODE[i], 8'h00);
      rd(16'hFF22, 8'hFF);
      // register table rows: write, then read back
      foreach (regs[i]) begin
         wr(regs[i].a, regs[i].d);
         rd(regs[i].a, regs[i].e);
      end
      chk(port2_direction, 16'h00A5);
      for (int i = 0; i < 3; i++) wr(tmr8_pkg::ADDR_MODE[i], 8'h00);
      // counter 1 on the subsystem clock, compare 2
      wr(16'hFF5C, 8'h04);
      wr(16'hFF55, 8'h02);
      wr(16'hFF5C, 8'h84);
      base = irq_cnt[1];
      pulse(1'b1);
      pulse(1'b1);
      rd(16'hFF51, 8'h02);
      chk(16'(irq_cnt[1] - base), 16'h0000);
      pulse(1'b1);
      rd(16'hFF51, 8'h00);
      chk(16'(irq_cnt[1] - base), 16'h0001);
      wr(16'hFF5C, 8'h00);
      // counter 0 on both input edges, compare 00 counts every pulse
      for (int c = 2; c < 4; c++) begin
         wr(16'hFF22, 8'hFF);
         wr(16'hFF59, 8'(c << 1));
         wr(16'hFF54, 8'h00);
         wr(16'hFF59, 8'h80 | 8'(c << 1));
         base = irq_cnt[0];
         repeat (3) pulse(1'b0);
         chk(16'(irq_cnt[0] - base), 16'h0003);
         rd(16'hFF50, 8'h00);
         wr(16'hFF59, 8'h00);
      end
      wr(16'hFF59, 8'h04);
      wr(16'hFF54, 8'h05);
      wr(16'hFF59, 8'h84);
      pulse(1'b0);
      pulse(1'b0);
      rd(16'hFF50, 8'h02);
      wr(16'hFF59, 8'h04);
      rd(16'hFF50, 8'h00);
      pulse(1'b0);
      rd(16'hFF50, 8'h00);
      // square wave on counter 2, divide by 8, compare 1
      wr(16'hFF22, 8'hDF);
      wr(16'hFF5F, 8'h01);
      wr(16'hFF56, 8'h01);
      wr(16'hFF5F, 8'h81);
      #1 chk(square_wave_out, 16'h0000);
      chk(square_wave_oe, 16'h0001);
      base = irq_cnt[2];
      for (int k = 1; k < 4; k++) begin
         wait_irq(2, base + k);
         #1 chk(square_wave_out, 16'(k % 2));
         @(posedge mclk);
      end
      wr(16'hFF5F, 8'h01);
      #1 chk(square_wave_out, 16'h0000);
      chk(square_wave_oe, 16'h0001);
      @(posedge mclk);
      wr(16'hFF5F, 8'h00);
      #1 chk(square_wave_oe, 16'h0000);
      @(posedge mclk);
      // prescaled sources: interrupt spacing is (N+1) source periods
      foreach (ticks[i]) begin
         wr(tmr8_pkg::ADDR_MODE[ticks[i].ch], 8'(ticks[i].code << 1));
         wr(tmr8_pkg::ADDR_CMP[ticks[i].ch], ticks[i].cmp);
         wr(tmr8_pkg::ADDR_MODE[ticks[i].ch], 8'h80 | 8'(ticks[i].code << 1));
         base = irq_cnt[ticks[i].ch];
         wait_irq(ticks[i].ch, base + 3);
         #1 chk(per[ticks[i].ch], ticks[i].per);
         @(posedge mclk);
         wr(tmr8_pkg::ADDR_MODE[ticks[i].ch], 8'h00);
      end
      // counter 2 on subclock with output on, counter 1 on the unused code
      wr(16'hFF5F, 8'h05);
      wr(16'hFF56, 8'h00);
      wr(16'hFF5F, 8'h85);
      wr(16'hFF5C, 8'h06);
      wr(16'hFF55, 8'h01);
      wr(16'hFF5C, 8'h86);
      base = irq_cnt[2];
      repeat (3) pulse(1'b1);
      chk(16'(irq_cnt[2] - base), 16'h0003);
      chk(square_wave_out, 16'h0001);
      rd(16'hFF51, 8'h00);
      // reset in mid-run while both counters run
      rstn <= 1'b0;
      @(posedge mclk);
      #1 chk(port2_direction, 16'h00FF);
      chk(square_wave_out, 16'h0000);
      chk(square_wave_oe, 16'h0000);
      chk(match_irq, 16'h0000);
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      rd(tmr8_pkg::ADDR_MODE[2], 8'h00);
      rd(16'hFF52, 8'h00);
      end_of_test();
   end
endmodule : test_triple_8bit_interval_timer
`default_nettype wire
